// ===== design/sra_params.svh
`ifndef SRA_PARAMS_SVH
`define SRA_PARAMS_SVH

`define SRA_FRAME_BITS    5'h10
`define SRA_HDR_BITS      5'h04
`define SRA_LAST_DATA_CNT 5'h0F
`define SRA_CNT_MAX       5'h1F
`define SRA_DATA_W        12

`define SRA_GRP_A         2'h0
`define SRA_GRP_B         2'h1
`define SRA_GRP_C         2'h2
`define SRA_GRP_D         2'h3

`define SRA_W_MODE        0
`define SRA_W_EVT_EN      1
`define SRA_W_SPECIAL     2
`define SRA_W_SYS_SETUP   3
`define SRA_W_SCRATCH0    4
`define SRA_W_XCVR        5
`define SRA_W_SCRATCH1    6
`define SRA_W_COUNT       7
`define SRA_R_COUNT       8

`define SRA_RST_WREG      12'h000
`define SRA_MISCOUNT_IE   0
`define SRA_SYNC_STAGES   3

`endif

// ===== design/sra_pkg.sv
`default_nettype none
`include "sra_params.svh"
package sra_pkg;

  // Gray codes along start-up, normal, standby, sleep.
  typedef enum logic [2:0] {
    SRA_ST_STARTUP  = 3'h0,
    SRA_ST_NORMAL   = 3'h1,
    SRA_ST_STANDBY  = 3'h3,
    SRA_ST_SLEEP    = 3'h2,
    SRA_ST_FLASH    = 3'h6,
    SRA_ST_RESTART  = 3'h7,
    SRA_ST_FAILSAFE = 3'h5
  } sra_op_state_t;

  typedef struct packed {
    logic [1:0] group_addr;
    logic       read_target_select;
    logic       no_write_flag;
  } sra_header_t;

  typedef struct packed {
    logic [`SRA_DATA_W-1:0] system_state_readback;
    logic [`SRA_DATA_W-1:0] fault_diagnosis_readback;
    logic [`SRA_DATA_W-1:0] event_flags;
  } sra_readback_t;

  typedef struct packed {
    logic [`SRA_DATA_W-1:0] mode_control;
    logic [`SRA_DATA_W-1:0] event_enable;
    logic [`SRA_DATA_W-1:0] special_setup;
    logic [`SRA_DATA_W-1:0] system_setup;
    logic [`SRA_DATA_W-1:0] scratch_store_zero;
    logic [`SRA_DATA_W-1:0] transceiver_control;
    logic [`SRA_DATA_W-1:0] scratch_store_one;
  } sra_wregs_t;

endpackage : sra_pkg
`default_nettype wire

// ===== design/sra_top.sv
`default_nettype none
`include "sra_params.svh"
module sra_top
  import sra_pkg::*;
(
  // System clock and reset
  input  wire logic          ref_clk,
  input  wire logic          nrst,
  // Serial link, clocked by the host
  input  wire logic          serial_clk,
  input  wire logic          frame_select_n,
  input  wire logic          serial_in,
  output var  logic          serial_out,
  // Device state and readback sources
  input  wire sra_op_state_t op_state,
  input  wire sra_readback_t readback,
  // Written registers
  output var  sra_wregs_t    wregs,
  // Frame events, one ref_clk cycle each
  output var  logic          frame_done_pulse,
  output var  logic          flags_read_pulse,
  output var  logic          miscount_irq_pulse,
  output var  logic          miscount_reset_pulse
);

  typedef logic [`SRA_DATA_W-1:0] sra_word_t;

  function automatic logic sra_setup_state(input sra_op_state_t st);
    sra_setup_state = (st == SRA_ST_STARTUP) || (st == SRA_ST_RESTART);
  endfunction : sra_setup_state

  // ---------------------------------------------------------------------
  // Link domain. The host clock stops between frames, so nothing here
  // waits for an edge after the last one of a frame.
  // ---------------------------------------------------------------------
  logic        armed_ff;
  logic [4:0]  link_cnt_ff;
  logic [15:0] link_shift_ff;
  logic [3:0]  link_hdr_ff;
  logic [4:0]  nxt_link_cnt;
  logic [15:0] nxt_link_shift;
  logic [3:0]  nxt_link_hdr;
  logic        nxt_serial_out;

  // Armed is forced while the select is high, so the first falling edge
  // of a frame restarts the count without a reset pulse in this domain.
  always_ff @(negedge serial_clk or posedge frame_select_n or negedge nrst) begin
    if (!nrst) begin
      armed_ff <= 1'b1;
    end else if (frame_select_n) begin
      armed_ff <= 1'b1;
    end else begin
      armed_ff <= 1'b0;
    end
  end

  assign nxt_link_cnt   = armed_ff ? 5'h01 :
                          (link_cnt_ff == `SRA_CNT_MAX) ? link_cnt_ff : 5'(link_cnt_ff + 5'h01);
  assign nxt_link_shift = armed_ff ? {15'h0000, serial_in} : {link_shift_ff[14:0], serial_in};
  assign nxt_link_hdr   = armed_ff ? {3'h0, serial_in} :
                          (link_cnt_ff < `SRA_HDR_BITS) ? {link_hdr_ff[2:0], serial_in} : link_hdr_ff;

  // Incoming data is captured on the falling edge.
  always_ff @(negedge serial_clk or negedge nrst) begin
    if (!nrst) begin
      link_cnt_ff   <= 5'h00;
      link_shift_ff <= 16'h0000;
      link_hdr_ff   <= 4'h0;
    end else begin
      link_cnt_ff   <= nxt_link_cnt;
      link_shift_ff <= nxt_link_shift;
      link_hdr_ff   <= nxt_link_hdr;
    end
  end

  // Readback snapshot, frozen by the ref domain for the whole frame.
  sra_word_t  snap_ff [`SRA_R_COUNT];
  sra_header_t link_hdr;
  sra_word_t  rd_word;
  logic [4:0] rd_idx;

  assign link_hdr = sra_header_t'(link_hdr_ff);
  assign rd_word  = snap_ff[{link_hdr.group_addr, link_hdr.read_target_select}];
  assign rd_idx   = 5'(`SRA_FRAME_BITS - link_cnt_ff);

  // An echoed bit can only leave after it was sampled, so the answer trails
  // the host's bits by one slot and readback bit 0 never leaves the chip.
  assign nxt_serial_out = armed_ff ? 1'b0 :
                          (link_cnt_ff <= `SRA_HDR_BITS) ? link_hdr_ff[0] :
                          (link_cnt_ff <= `SRA_LAST_DATA_CNT) ? rd_word[rd_idx[3:0]] :
                          1'b0;

  // Outgoing data is launched on the rising edge, one bit per clock.
  always_ff @(posedge serial_clk or negedge nrst) begin
    if (!nrst) begin
      serial_out <= 1'b0;
    end else begin
      serial_out <= nxt_serial_out;
    end
  end

  // ---------------------------------------------------------------------
  // Ref domain.
  // ---------------------------------------------------------------------
  logic [`SRA_SYNC_STAGES-1:0] cs_sync_ff;
  logic                        cs_level_ff;
  logic                        nxt_cs_level;
  logic                        frame_end_ff;

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      cs_sync_ff <= 3'h7;
    end else begin
      cs_sync_ff <= {cs_sync_ff[1:0], frame_select_n};
    end
  end

  assign nxt_cs_level = (cs_sync_ff[1] == cs_sync_ff[2]) ? cs_sync_ff[2] : cs_level_ff;

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      cs_level_ff  <= 1'b1;
      frame_end_ff <= 1'b0;
    end else begin
      cs_level_ff  <= nxt_cs_level;
      frame_end_ff <= nxt_cs_level & ~cs_level_ff;
    end
  end

  // The link words are read only after the select has been high for the
  // synchroniser delay; the stopped host clock keeps them still meanwhile.
  sra_header_t hdr;
  sra_word_t   payload;
  logic        cnt_ok;
  logic        accept;
  logic        do_write;
  logic        in_setup;
  logic        scratch_ok;
  logic        irq_state;

  assign hdr        = sra_header_t'(link_hdr_ff);
  assign payload    = link_shift_ff[`SRA_DATA_W-1:0];
  assign cnt_ok     = (link_cnt_ff == `SRA_FRAME_BITS);
  assign accept     = frame_end_ff & cnt_ok;
  assign do_write   = accept & ~hdr.no_write_flag;
  assign in_setup   = sra_setup_state(op_state);
  assign scratch_ok = in_setup || (op_state == SRA_ST_FLASH);
  assign irq_state  = (op_state == SRA_ST_NORMAL) || (op_state == SRA_ST_STANDBY) ||
                      (op_state == SRA_ST_FLASH);

  logic [`SRA_W_COUNT-1:0] wr_strobe;
  logic                    grp_a;
  logic                    grp_b;
  logic                    grp_c;
  logic                    grp_d;

  assign grp_a = (hdr.group_addr == `SRA_GRP_A);
  assign grp_b = (hdr.group_addr == `SRA_GRP_B);
  assign grp_c = (hdr.group_addr == `SRA_GRP_C);
  assign grp_d = (hdr.group_addr == `SRA_GRP_D);

  assign wr_strobe[`SRA_W_MODE]      = do_write & grp_a;
  assign wr_strobe[`SRA_W_EVT_EN]    = do_write & grp_b & ~in_setup;
  assign wr_strobe[`SRA_W_SPECIAL]   = do_write & grp_b & in_setup;
  assign wr_strobe[`SRA_W_SYS_SETUP] = do_write & grp_c & ~hdr.read_target_select;
  assign wr_strobe[`SRA_W_SCRATCH0]  = do_write & grp_c & hdr.read_target_select & scratch_ok;
  assign wr_strobe[`SRA_W_XCVR]      = do_write & grp_d & ~hdr.read_target_select;
  assign wr_strobe[`SRA_W_SCRATCH1]  = do_write & grp_d & hdr.read_target_select & scratch_ok;

  sra_word_t wreg_ff [`SRA_W_COUNT];

  genvar gi;
  generate
    for (gi = 0; gi < `SRA_W_COUNT; gi++) begin : g_wreg
      always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
          wreg_ff[gi] <= `SRA_RST_WREG;
        end else if (wr_strobe[gi]) begin
          wreg_ff[gi] <= payload;
        end
      end
    end
  endgenerate

  assign wregs.mode_control        = wreg_ff[`SRA_W_MODE];
  assign wregs.event_enable        = wreg_ff[`SRA_W_EVT_EN];
  assign wregs.special_setup       = wreg_ff[`SRA_W_SPECIAL];
  assign wregs.system_setup        = wreg_ff[`SRA_W_SYS_SETUP];
  assign wregs.scratch_store_zero  = wreg_ff[`SRA_W_SCRATCH0];
  assign wregs.transceiver_control = wreg_ff[`SRA_W_XCVR];
  assign wregs.scratch_store_one   = wreg_ff[`SRA_W_SCRATCH1];

  // Readback sources in order of {group, select}; feedback comes from the
  // registers themselves.
  sra_word_t live [`SRA_R_COUNT];

  assign live[0] = readback.system_state_readback;
  assign live[1] = readback.fault_diagnosis_readback;
  assign live[2] = wreg_ff[`SRA_W_EVT_EN];
  assign live[3] = in_setup ? wreg_ff[`SRA_W_SPECIAL] : readback.event_flags;
  assign live[4] = wreg_ff[`SRA_W_SYS_SETUP];
  assign live[5] = wreg_ff[`SRA_W_SCRATCH0];
  assign live[6] = wreg_ff[`SRA_W_XCVR];
  assign live[7] = wreg_ff[`SRA_W_SCRATCH1];

  // The snapshot follows its sources only while no frame runs, so the link
  // side never sees a word change under its clock.
  logic snap_track;

  assign snap_track = cs_level_ff & nxt_cs_level;

  generate
    for (gi = 0; gi < `SRA_R_COUNT; gi++) begin : g_snap
      always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
          snap_ff[gi] <= `SRA_RST_WREG;
        end else if (snap_track) begin
          snap_ff[gi] <= live[gi];
        end
      end
    end
  endgenerate

  // Frame outcome events.
  logic nxt_flags_read;
  logic nxt_miscount_irq;
  logic nxt_miscount_reset;
  logic miscount;

  assign miscount           = frame_end_ff & ~cnt_ok;
  assign nxt_flags_read     = accept & grp_b & hdr.read_target_select & ~in_setup;
  assign nxt_miscount_reset = miscount & in_setup;
  assign nxt_miscount_irq   = miscount & irq_state & wreg_ff[`SRA_W_EVT_EN][`SRA_MISCOUNT_IE];

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      frame_done_pulse     <= 1'b0;
      flags_read_pulse     <= 1'b0;
      miscount_irq_pulse   <= 1'b0;
      miscount_reset_pulse <= 1'b0;
    end else begin
      frame_done_pulse     <= accept;
      flags_read_pulse     <= nxt_flags_read;
      miscount_irq_pulse   <= nxt_miscount_irq;
      miscount_reset_pulse <= nxt_miscount_reset;
    end
  end

endmodule : sra_top
`default_nettype wire

// ===== verification/sra_top_sva.sv
`default_nettype none
module sra_top_chk
  import sra_pkg::*;
(
  // Watched ports
  input wire logic          ref_clk,
  input wire logic          nrst,
  input wire logic          serial_clk,
  input wire logic          serial_out,
  input wire sra_op_state_t op_state,
  input wire sra_wregs_t    wregs,
  input wire logic          frame_done_pulse,
  input wire logic          flags_read_pulse,
  input wire logic          miscount_irq_pulse,
  input wire logic          miscount_reset_pulse
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  wire logic boot = op_state inside {SRA_ST_STARTUP, SRA_ST_RESTART};
  a_done_one_cycle: assert property (frame_done_pulse |=> !frame_done_pulse)
    else $error("frame done pulse held");
  a_done_excl_miscount: assert property (frame_done_pulse |-> !(miscount_irq_pulse || miscount_reset_pulse))
    else $error("accepted frame flagged as miscount");
  a_flags_need_done: assert property (flags_read_pulse |-> frame_done_pulse && !boot)
    else $error("flags read without accepted frame");
  a_reset_in_boot: assert property (miscount_reset_pulse |-> boot)
    else $error("miscount reset outside boot states");
  a_irq_when_enabled: assert property (miscount_irq_pulse |-> wregs.event_enable[0] && !boot &&
    op_state inside {SRA_ST_NORMAL, SRA_ST_STANDBY, SRA_ST_FLASH}) else $error("miscount irq not allowed");
  a_write_needs_done: assert property ($changed(wregs) |-> frame_done_pulse)
    else $error("register changed without frame");
  a_scratch_gated: assert property ($changed(wregs.scratch_store_zero) |-> boot || op_state == SRA_ST_FLASH)
    else $error("scratch written in locked state");
  a_special_gated: assert property ($changed(wregs.special_setup) |-> boot)
    else $error("special setup written outside boot");
  a_out_on_rise: assert property ($changed(serial_out) |-> serial_clk)
    else $error("serial out moved off rising edge");
endmodule : sra_top_chk
bind sra_top sra_top_chk u_chk (.ref_clk(ref_clk), .nrst(nrst), .serial_clk(serial_clk), .serial_out(serial_out),
  .op_state(op_state), .wregs(wregs), .frame_done_pulse(frame_done_pulse), .flags_read_pulse(flags_read_pulse),
  .miscount_irq_pulse(miscount_irq_pulse), .miscount_reset_pulse(miscount_reset_pulse));
`default_nettype wire

// ===== verification/sra_host.sv
`default_nettype none
module sra_host (
  // Link toward the device
  output var logic serial_clk,
  output var logic frame_select_n,
  output var logic serial_in,
  // Device answer
  input  wire logic serial_out
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    serial_clk     = 1'b0;
    frame_select_n = 1'b1;
    serial_in      = 1'b0;
  end
  // Data moves 1 ns after the falling edge so the device never sees it change at its sampling edge.
  task automatic xfer(input logic [16:0] word, input int nbits, output logic [15:0] rx);
    rx = 16'h0000;
    frame_select_n = 1'b0;
    for (int k = nbits - 1; k >= 0; k--) begin
      serial_in = word[k];
      #14 serial_clk = 1'b1;
      #15 rx = {rx[14:0], serial_out};
      serial_clk = 1'b0;
      #1;
    end
    #14 frame_select_n = 1'b1;
    serial_in = ~serial_in;
    #200;
  endtask : xfer
endmodule : sra_host
`default_nettype wire

// ===== verification/sra_top_tb_top.sv
`default_nettype none
module sra_top_tb_top
  import sra_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct packed {
    logic [3:0] pulses;
    sra_wregs_t wregs;
  } sra_exp_t;
  logic          ref_clk = 1'b0;
  logic          nrst = 1'b0;
  wire logic     serial_clk, frame_select_n, serial_in, serial_out;
  sra_op_state_t op_state = SRA_ST_STARTUP;
  sra_readback_t readback = '0;
  sra_wregs_t    wregs, mdl;
  logic          done_p, flags_p, irq_p, rst_p;
  sra_exp_t      exp_q[$];
  int            n_errors = 0, check_count = 0, seed = 2950, cycles = 0;
  sra_op_state_t states[7] = '{SRA_ST_STARTUP, SRA_ST_NORMAL, SRA_ST_STANDBY, SRA_ST_SLEEP,
                               SRA_ST_FLASH, SRA_ST_RESTART, SRA_ST_FAILSAFE};
  always #5 ref_clk = ~ref_clk;
  sra_host host (.serial_clk(serial_clk), .frame_select_n(frame_select_n), .serial_in(serial_in),
    .serial_out(serial_out));
  sra_top DUT (.ref_clk(ref_clk), .nrst(nrst), .serial_clk(serial_clk), .frame_select_n(frame_select_n),
    .serial_in(serial_in), .serial_out(serial_out), .op_state(op_state), .readback(readback), .wregs(wregs),
    .frame_done_pulse(done_p), .flags_read_pulse(flags_p), .miscount_irq_pulse(irq_p),
    .miscount_reset_pulse(rst_p));
  task automatic cmp_exp(input sra_exp_t e, input sra_exp_t g);
    check_count++;
    if (g !== e) begin
      n_errors++;
      $display("mismatch at %0t: expected %h got %h", $time, e, g);
    end
  endtask : cmp_exp
  task automatic cmp_rx(input logic [15:0] e, input logic [15:0] g);
    check_count++;
    if (g !== e) begin
      n_errors++;
      $display("mismatch at %0t: expected %h got %h", $time, e, g);
    end
  endtask : cmp_rx
  // A note still queued after the answer window means a frame outcome never appeared.
  task automatic cmp_left(input int e, input int g);
    check_count++;
    if (g !== e) begin
      n_errors++;
      $display("mismatch at %0t: expected %h got %h", $time, e, g);
    end
  endtask : cmp_left
  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : complete_run
  // A pulse with nothing queued is itself an error, so silent miscounts are checked too.
  always @(posedge ref_clk) begin
    cycles++;
    if (nrst && (done_p | flags_p | irq_p | rst_p)) begin
      if (exp_q.size() == 0) cmp_exp('0, {done_p, flags_p, irq_p, rst_p, wregs});
      else cmp_exp(exp_q.pop_front(), {done_p, flags_p, irq_p, rst_p, wregs});
    end
    if (cycles == 20000) begin
      n_errors++;
      complete_run();
    end
  end
  task automatic set_state(input sra_op_state_t st);
    logic [63:0] r;
    r = {$random(seed), $random(seed)};
    @(posedge ref_clk);
    op_state <= st;
    readback <= r[35:0];
    repeat (4) @(posedge ref_clk);
  endtask : set_state
  task automatic run_frame(input logic [3:0] hdr, input logic [11:0] pay, input int nbits);
    logic        boot, scr;
    logic [11:0] rd;
    logic [15:0] rx;
    sra_exp_t    e;
    boot = op_state inside {SRA_ST_STARTUP, SRA_ST_RESTART};
    scr = boot || op_state == SRA_ST_FLASH;
    case (hdr[3:1])
      3'h0: rd = readback.system_state_readback;
      3'h1: rd = readback.fault_diagnosis_readback;
      3'h2: rd = mdl.event_enable;
      3'h3: rd = boot ? mdl.special_setup : readback.event_flags;
      3'h4: rd = mdl.system_setup;
      3'h5: rd = mdl.scratch_store_zero;
      3'h6: rd = mdl.transceiver_control;
      default: rd = mdl.scratch_store_one;
    endcase
    e.pulses = {2'b00, !boot && mdl.event_enable[0] && op_state inside {SRA_ST_NORMAL, SRA_ST_STANDBY,
      SRA_ST_FLASH}, boot};
    if (nbits == 16) begin
      e.pulses = {1'b1, hdr[3:1] == 3'h3 && !boot, 2'b00};
      if (!hdr[0]) begin
        case (hdr[3:2])
          2'h0: mdl.mode_control = pay;
          2'h1: if (boot) mdl.special_setup = pay; else mdl.event_enable = pay;
          2'h2: if (!hdr[1]) mdl.system_setup = pay; else if (scr) mdl.scratch_store_zero = pay;
          default: if (!hdr[1]) mdl.transceiver_control = pay; else if (scr) mdl.scratch_store_one = pay;
        endcase
      end
    end
    e.wregs = mdl;
    if (e.pulses != 4'h0) exp_q.push_back(e);
    host.xfer({hdr, pay, 1'b1} >> (17 - nbits), nbits, rx);
    if (nbits == 16) cmp_rx({1'b0, hdr, rd[11:1]}, rx);
    cmp_left(0, exp_q.size());
  endtask : run_frame
  initial begin
    logic [15:0] w;
    mdl = '0;
    repeat (16) @(posedge ref_clk);
    nrst <= 1'b1;
    set_state(SRA_ST_STARTUP);
    cmp_exp('0, {4'h0, wregs});
    for (int i = 0; i < 16; i++) run_frame(i[3:0], 12'hA5C ^ 12'(i * 291), 16);
    $display("test directed map done");
    foreach (states[s]) begin
      set_state(states[s]);
      run_frame(4'h4, 12'(s & 1), 16);
      run_frame(4'h7, 12'h0000, 16);
      run_frame(4'h0, 12'h0FFF, 15);
      run_frame(4'hA, 12'h0123, 17);
    end
    $display("test miscount per state done");
    for (int i = 0; i < 60; i++) begin
      set_state(states[$unsigned($random(seed)) % 7]);
      w = 16'($random(seed));
      run_frame(w[15:12], w[11:0], (i % 4 == 3) ? 15 + 2 * (i % 8 / 4) : 16);
    end
    $display("test random frames done");
    complete_run();
  end
endmodule : sra_top_tb_top
`default_nettype wire
